// *** src/irq_ctl.sv ***
// maskable interrupt controller: per-source control registers behind axi4-lite
`timescale 1ns/1ps
`include "irq_ctl_regs.svh"
module irq_ctl #(
  parameter int NS = `IRQC_SLOTS
) (
  // clock and reset
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  // axi4-lite write address and data
  input  wire logic                   awvalid,
  output logic                        awready,
  input  wire logic [13:0]            awaddr,
  input  wire logic [2:0]             awprot,
  input  wire logic                   wvalid,
  output logic                        wready,
  input  wire logic [31:0]            wdata,
  input  wire logic [3:0]             wstrb,
  // axi4-lite write response
  output logic                        bvalid,
  input  wire logic                   bready,
  output logic [1:0]                  bresp,
  // axi4-lite read
  input  wire logic                   arvalid,
  output logic                        arready,
  input  wire logic [13:0]            araddr,
  input  wire logic [2:0]             arprot,
  output logic                        rvalid,
  input  wire logic                   rready,
  output logic [31:0]                 rdata,
  output logic [1:0]                  rresp,
  // peripheral request pulses, one per slot
  input  wire logic [NS-1:0]          src_req,
  // cpu core side
  input  wire logic                   cpu_ack,
  input  wire logic [5:0]             cpu_ack_id,
  input  wire logic                   interrupts_off_instruction,
  input  wire logic                   interrupts_on_instruction,
  output irq_ctl_pkg::irq_req_s       irq_o,
  output logic                        irq_disabled
);

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  localparam logic [NS-1:0] SLOT_USED = `IRQC_SLOT_USED;

  // maps a byte address to {hit, slot}; bits 13:12 pick write/set/clear
  function automatic logic [6:0] decode(input logic [13:0] a);
    logic [9:0] idx;
    logic [9:0] off;
    logic       hit;
    idx = a[11:2];
    off = idx - `IRQC_BASE_INDEX;
    hit = (idx >= `IRQC_BASE_INDEX) && (off < 10'(2 * NS)) && !off[0]
          && (a[13:12] != 2'h3) && (a[1:0] == 2'h0);
    if (hit) begin
      hit = SLOT_USED[off[6:1]];
    end
    decode = {hit, off[6:1]};
  endfunction

  // lowest level wins, lower slot wins a tie
  function automatic logic [9:0] pick(input logic [NS-1:0][7:0] c);
    logic       found;
    logic [5:0] id;
    logic [2:0] lvl;
    found = 1'b0;
    id    = 6'h00;
    lvl   = 3'h7;
    for (int i = 0; i < NS; i++) begin
      if (SLOT_USED[i] && c[i][`IRQC_REQ_BIT] && !c[i][`IRQC_MASK_BIT]) begin
        if (!found || (c[i][2:0] < lvl)) begin
          found = 1'b1;
          id    = 6'(i);
          lvl   = c[i][2:0];
        end
      end
    end
    pick = {found, id, lvl};
  endfunction

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  irq_ctl_pkg::state_s s_q;
  irq_ctl_pkg::state_s s_d;
  logic [9:0]          best;
  logic [6:0]          wdec;
  logic [6:0]          rdec;
  logic [7:0]          cur;
  logic [7:0]          nxt;

  assign best = pick(s_q.ctl);
  assign wdec = decode(s_q.waddr);
  assign rdec = decode(araddr);

  // next-state logic
  always_comb begin
    s_d = s_q;
    cur = 8'h00;
    nxt = 8'h00;
    // capture address and data in either order
    if (awvalid && s_q.awready) begin
      s_d.aw_held = 1'b1;
      s_d.waddr   = awaddr;
    end
    if (wvalid && s_q.wready) begin
      s_d.w_held = 1'b1;
      s_d.wdat   = wdata[7:0];
      s_d.wstrb0 = wstrb[0];
    end
    if (s_q.bvalid && bready) begin
      s_d.bvalid = 1'b0;
    end
    // perform the write once both halves are held
    if (s_q.aw_held && s_q.w_held && !s_q.bvalid) begin
      s_d.aw_held = 1'b0;
      s_d.w_held  = 1'b0;
      s_d.bvalid  = 1'b1;
      s_d.bresp   = wdec[6] ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
      if (wdec[6] && s_q.wstrb0) begin
        cur = s_q.ctl[wdec[5:0]];
        unique case (s_q.waddr[13:12])
          `IRQC_OP_WRITE: nxt = s_q.wdat;
          `IRQC_OP_SET:   nxt = cur | s_q.wdat;
          `IRQC_OP_CLEAR: nxt = cur & ~s_q.wdat;
          default:        nxt = cur;
        endcase
        s_d.ctl[wdec[5:0]] = nxt & ~`IRQC_RSVD_MASK;
      end
    end
    // hardware flag updates after software, so a request beats any clear
    for (int i = 0; i < NS; i++) begin
      if (cpu_ack && (cpu_ack_id == 6'(i))) begin
        s_d.ctl[i][`IRQC_REQ_BIT] = 1'b0;
      end
      if (src_req[i] && SLOT_USED[i]) begin
        s_d.ctl[i][`IRQC_REQ_BIT] = 1'b1;
      end
    end
    // interrupts-disabled state of the cpu
    if (interrupts_on_instruction) begin
      s_d.dis = 1'b0;
    end
    if (interrupts_off_instruction || cpu_ack) begin
      s_d.dis = 1'b1;
    end
    // read channel
    if (s_q.rvalid && rready) begin
      s_d.rvalid = 1'b0;
    end
    if (arvalid && s_q.arready) begin
      s_d.rvalid = 1'b1;
      s_d.rdata  = rdec[6] ? {24'h00_0000, s_q.ctl[rdec[5:0]]} : 32'h0000_0000;
      s_d.rresp  = rdec[6] ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
    end
    s_d.awready = !s_d.aw_held && !s_d.bvalid;
    s_d.wready  = !s_d.w_held && !s_d.bvalid;
    s_d.arready = !s_d.rvalid;
    // offer held request only while interrupts are enabled
    s_d.irq.valid = best[9] && !s_q.dis && !cpu_ack;
    s_d.irq.id    = best[8:3];
    s_d.irq.level = best[2:0];
  end

  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q         <= '0;
      s_q.ctl     <= {NS{`IRQC_CTL_RESET}};
      s_q.awready <= 1'b1;
      s_q.wready  <= 1'b1;
      s_q.arready <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state register
  assign awready      = s_q.awready;
  assign wready       = s_q.wready;
  assign bvalid       = s_q.bvalid;
  assign bresp        = s_q.bresp;
  assign arready      = s_q.arready;
  assign rvalid       = s_q.rvalid;
  assign rdata        = s_q.rdata;
  assign rresp        = s_q.rresp;
  assign irq_o        = s_q.irq;
  assign irq_disabled = s_q.dis;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence both_taken_s;
    s_q.aw_held && s_q.w_held && !s_q.bvalid;
  endsequence

  sequence resp_s;
    bvalid [*1];
  endsequence

  logic [7:0] rsvd_or;
  always_comb begin
    rsvd_or = 8'h00;
    for (int i = 0; i < NS; i++) begin
      rsvd_or = rsvd_or | (s_q.ctl[i] & `IRQC_RSVD_MASK);
    end
  end

  rsvd_bits_zero_a: assert property (rsvd_or == 8'h00)
    else $error("reserved control bits not zero");
  req_sets_flag_a: assert property (src_req[0] |=> s_q.ctl[0][`IRQC_REQ_BIT])
    else $error("request pulse did not set flag");
  ack_clears_flag_a: assert property (cpu_ack && (cpu_ack_id == 6'h01) && !src_req[1]
    |=> !s_q.ctl[1][`IRQC_REQ_BIT])
    else $error("acknowledge did not clear flag");
  ack_disables_a: assert property (cpu_ack |=> irq_disabled && !irq_o.valid)
    else $error("acknowledge did not disable interrupts");
  held_not_offered_a: assert property (irq_o.valid |-> !$past(s_q.dis))
    else $error("request offered while disabled");
  best_offered_a: assert property (irq_o.valid |-> irq_o.id == $past(best[8:3])
    && irq_o.level == $past(best[2:0]))
    else $error("offered source is not the best one");
  masked_never_a: assert property (s_q.ctl[0][`IRQC_MASK_BIT] && !s_q.dis
    |=> !(irq_o.valid && irq_o.id == 6'h00))
    else $error("masked source offered");
  write_resp_a: assert property (both_taken_s |=> resp_s)
    else $error("no write response after both halves");
  read_resp_a: assert property (
    arvalid && arready |=> rvalid && rdata[31:8] == 24'h00_0000)
    else $error("read answer missing or upper lanes set");
  read_hold_a: assert property (
    rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read answer not held");
  bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");

  // ----------------------------------------------------------------------
  // bus channel checks
  // ----------------------------------------------------------------------
  sequence aw_take_s;
    awvalid && awready;
  endsequence

  sequence w_take_s;
    wvalid && wready;
  endsequence

  // address and data taken together give a response two edges later
  write_turn_a: assert property (aw_take_s ##0 w_take_s |-> ##2 bvalid)
    else $error("write response late");

  // no address accepted while a response waits
  aw_refused_a: assert property (bvalid |-> !awready)
    else $error("write address accepted during response");

  // no data accepted while a response waits
  w_refused_a: assert property (bvalid |-> !wready)
    else $error("write data accepted during response");

  // no read address accepted while read data waits
  ar_refused_a: assert property (rvalid |-> !arready)
    else $error("read address accepted during answer");

  // write channels reopen right after the response handshake
  w_reopen_a: assert property (bvalid && bready |=> !bvalid && awready && wready)
    else $error("write channels not reopened");

  // read channel reopens right after the answer handshake
  r_reopen_a: assert property (rvalid && rready |=> !rvalid && arready)
    else $error("read channel not reopened");

  // response codes are okay or slave error only
  bresp_code_a: assert property (
    bvalid |-> (bresp == `AXI_RESP_OKAY) || (bresp == `AXI_RESP_SLVERR))
    else $error("illegal write response code");

  rresp_code_a: assert property (
    rvalid |-> (rresp == `AXI_RESP_OKAY) || (rresp == `AXI_RESP_SLVERR))
    else $error("illegal read response code");

  // upper byte lanes of read data always zero
  rdata_lanes_a: assert property (rvalid |-> rdata[31:8] == 24'h00_0000)
    else $error("upper read lanes not zero");

  // ----------------------------------------------------------------------
  // request flag checks
  // ----------------------------------------------------------------------
  logic sw_write;

  // software write performed this cycle
  assign sw_write = s_q.aw_held && s_q.w_held && !s_q.bvalid;

  // hole slots ignore writes and requests and keep their reset value
  hole_slot_a: assert property (s_q.ctl[9] == `IRQC_CTL_RESET)
    else $error("hole slot changed");

  // a pending flag stays until acknowledged or written
  pending_kept_a: assert property (
    s_q.ctl[0][`IRQC_REQ_BIT] && !cpu_ack && !sw_write |=> s_q.ctl[0][`IRQC_REQ_BIT])
    else $error("pending request lost");

  // no flag appears without a request or a write
  no_stray_flag_a: assert property (
    !s_q.ctl[0][`IRQC_REQ_BIT] && !src_req[0] && !sw_write |=> !s_q.ctl[0][`IRQC_REQ_BIT])
    else $error("flag set without a request");

  // a request beats a software clear in the same cycle
  req_beats_clear_a: assert property (
    src_req[7] && sw_write |=> s_q.ctl[7][`IRQC_REQ_BIT])
    else $error("software write swallowed a request");

  // mask and level change only through a software write
  fields_kept_a: assert property (
    !sw_write |=> $stable(s_q.ctl[0][6:0]))
    else $error("mask or level changed without a write");

  // ----------------------------------------------------------------------
  // offer checks
  // ----------------------------------------------------------------------
  logic       any_ready;
  logic [2:0] min_lvl;

  // lowest level among unmasked pending used slots
  always_comb begin
    any_ready = 1'b0;
    min_lvl   = 3'h7;
    for (int i = 0; i < NS; i++) begin
      if (SLOT_USED[i] && s_q.ctl[i][`IRQC_REQ_BIT] && !s_q.ctl[i][`IRQC_MASK_BIT]) begin
        any_ready = 1'b1;
        if (s_q.ctl[i][2:0] < min_lvl) begin
          min_lvl = s_q.ctl[i][2:0];
        end
      end
    end
  end

  sequence offer_due_s;
    any_ready && !s_q.dis && !cpu_ack;
  endsequence

  // an enabled pending source is offered at the lowest level
  lowest_offered_a: assert property (
    offer_due_s |=> irq_o.valid && (irq_o.level == $past(min_lvl)))
    else $error("lowest pending level not offered");

  // nothing pending, nothing offered
  idle_quiet_a: assert property (!any_ready |=> !irq_o.valid)
    else $error("offer without a pending source");

  // disabled state blocks the offer
  dis_blocks_a: assert property (s_q.dis |=> !irq_o.valid)
    else $error("offer while disabled");

  // the off instruction enters the disabled state
  off_enters_a: assert property (interrupts_off_instruction |=> irq_disabled)
    else $error("off instruction ignored");

  // the on instruction leaves it unless an acknowledge or the off instruction collides
  on_leaves_a: assert property (
    interrupts_on_instruction && !interrupts_off_instruction && !cpu_ack |=> !irq_disabled)
    else $error("on instruction ignored");

  // disabled state holds until the on instruction
  dis_holds_a: assert property (
    irq_disabled && !interrupts_on_instruction |=> irq_disabled)
    else $error("disabled state left early");

  // enabled state holds unless acknowledge or off instruction
  en_holds_a: assert property (
    !irq_disabled && !interrupts_off_instruction && !cpu_ack |=> !irq_disabled)
    else $error("disabled state entered early");

endmodule

// *** common/irq_ctl_regs.svh ***
// register map, field positions and reset values of the maskable interrupt controller
`ifndef IRQ_CTL_REGS_SVH
`define IRQ_CTL_REGS_SVH

// ----------------------------------------------------------------------
// register indices, byte address is four times the low index bits
// ----------------------------------------------------------------------
`define WATCHDOG_IRQ_CTL_IDX          32'hFFFF_F100
`define EXT_PIN0_IRQ_CTL_IDX          32'hFFFF_F102
`define EXT_PIN1_IRQ_CTL_IDX          32'hFFFF_F104
`define EXT_PIN2_IRQ_CTL_IDX          32'hFFFF_F106
`define EXT_PIN3_IRQ_CTL_IDX          32'hFFFF_F108
`define EXT_PIN4_IRQ_CTL_IDX          32'hFFFF_F10A
`define EXT_PIN5_IRQ_CTL_IDX          32'hFFFF_F10C
`define EXT_PIN6_IRQ_CTL_IDX          32'hFFFF_F10E
`define WATCH_PRESCALER_IRQ_CTL_IDX   32'hFFFF_F118
`define TIMER0_CH0_IRQ_CTL_IDX        32'hFFFF_F11A
`define TIMER0_CH1_IRQ_CTL_IDX        32'hFFFF_F11C
`define TIMER1_CH0_IRQ_CTL_IDX        32'hFFFF_F11E
`define TIMER1_CH1_IRQ_CTL_IDX        32'hFFFF_F120
`define TIMER2_IRQ_CTL_IDX            32'hFFFF_F122
`define TIMER3_IRQ_CTL_IDX            32'hFFFF_F124
`define TIMER4_IRQ_CTL_IDX            32'hFFFF_F126
`define TIMER5_IRQ_CTL_IDX            32'hFFFF_F128
`define TIMER6_IRQ_CTL_IDX            32'hFFFF_F12A
`define TIMER7_IRQ_CTL_IDX            32'hFFFF_F12C
`define CLOCKED_SERIAL0_IRQ_CTL_IDX   32'hFFFF_F12E
`define ASYNC_SERIAL0_ERR_IRQ_CTL_IDX 32'hFFFF_F130
`define CLOCKED_SERIAL1_IRQ_CTL_IDX   32'hFFFF_F132
`define ASYNC_SERIAL0_TX_IRQ_CTL_IDX  32'hFFFF_F134
`define CLOCKED_SERIAL2_IRQ_CTL_IDX   32'hFFFF_F136
`define TWO_WIRE_BUS1_IRQ_CTL_IDX     32'hFFFF_F138
`define ASYNC_SERIAL1_ERR_IRQ_CTL_IDX 32'hFFFF_F13A
`define CLOCKED_SERIAL3_IRQ_CTL_IDX   32'hFFFF_F13C
`define ASYNC_SERIAL1_TX_IRQ_CTL_IDX  32'hFFFF_F13E
`define CLOCKED_SERIAL4_IRQ_CTL_IDX   32'hFFFF_F140
`define VEHICLE_BUS_A_IRQ_CTL_IDX     32'hFFFF_F142
`define VEHICLE_BUS_B_IRQ_CTL_IDX     32'hFFFF_F144
`define ADC_DONE_IRQ_CTL_IDX          32'hFFFF_F146
`define DMA_CH0_IRQ_CTL_IDX           32'hFFFF_F148
`define DMA_CH1_IRQ_CTL_IDX           32'hFFFF_F14A
`define DMA_CH2_IRQ_CTL_IDX           32'hFFFF_F14C
`define DMA_CH3_IRQ_CTL_IDX           32'hFFFF_F14E
`define DMA_CH4_IRQ_CTL_IDX           32'hFFFF_F150
`define DMA_CH5_IRQ_CTL_IDX           32'hFFFF_F152
`define WATCH_TIMER_IRQ_CTL_IDX       32'hFFFF_F154
`define KEY_RETURN_IRQ_CTL_IDX        32'hFFFF_F156

// ----------------------------------------------------------------------
// slots, fields, reset values, bus codes
// ----------------------------------------------------------------------
`define IRQC_SLOTS      44
`define IRQC_BASE_INDEX 10'(`WATCHDOG_IRQ_CTL_IDX)
`define IRQC_SLOT_USED  44'hFFF_FFFF_F0FF
`define IRQC_REQ_BIT    7
`define IRQC_MASK_BIT   6
`define IRQC_RSVD_MASK  8'h38
`define IRQC_CTL_RESET  8'h47
`define IRQC_OP_WRITE   2'h0
`define IRQC_OP_SET     2'h1
`define IRQC_OP_CLEAR   2'h2
`define AXI_RESP_OKAY   2'h0
`define AXI_RESP_SLVERR 2'h2

`endif

// *** common/irq_ctl_pkg.sv ***
// types shared by the maskable interrupt controller
`include "irq_ctl_regs.svh"
package irq_ctl_pkg;

  // ----------------------------------------------------------------------
  // request offered to the cpu core
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic       valid;
    logic [5:0] id;
    logic [2:0] level;
  } irq_req_s;

  // ----------------------------------------------------------------------
  // complete register state of the controller
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [`IRQC_SLOTS-1:0][7:0] ctl;
    logic                        dis;
    logic                        aw_held;
    logic                        w_held;
    logic [13:0]                 waddr;
    logic [7:0]                  wdat;
    logic                        wstrb0;
    logic                        awready;
    logic                        wready;
    logic                        bvalid;
    logic [1:0]                  bresp;
    logic                        arready;
    logic                        rvalid;
    logic [31:0]                 rdata;
    logic [1:0]                  rresp;
    irq_req_s                    irq;
  } state_s;

endpackage

// *** sim/cpu_core_model.sv ***
// cpu core model that takes offered maskable requests after a set wait
`timescale 1ns/1ps
module cpu_core_model (
  // clock, reset and bench control
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic                  ack_en,
  input  wire logic [3:0]            ack_dly,
  // controller side
  input  wire irq_ctl_pkg::irq_req_s irq_o,
  output logic                       cpu_ack,
  output logic [5:0]                 cpu_ack_id,
  output logic [5:0]                 last_id
);
  logic [3:0] wait_q;

  // acknowledge only a request on offer, one pulse each
  always_ff @(posedge aclk) begin
    cpu_ack <= 1'b0;
    if (!aresetn) begin
      wait_q  <= 4'h0;
      last_id <= 6'h00;
    end else if (ack_en && irq_o.valid && !cpu_ack) begin
      wait_q <= wait_q + 4'h1;
      if (wait_q >= ack_dly) begin
        cpu_ack <= 1'b1;
        last_id <= irq_o.id;
        wait_q  <= 4'h0;
      end
    end else begin
      wait_q <= 4'h0;
    end
  end

  // id travels with the pulse
  assign cpu_ack_id = last_id;
endmodule

// *** sim/testbench.sv ***
// self-checking bench for the maskable interrupt control registers
`timescale 1ns/1ps
module testbench;
  // ---------------------------------
  // signals and instances
  // ---------------------------------
  logic                  aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic                  ack_en, ion, ioff, awready, wready, bvalid, arready, rvalid;
  logic                  cpu_ack, irq_disabled;
  logic [13:0]           awaddr, araddr;
  logic [31:0]           wdata, rdata;
  logic [3:0]            wstrb, dly;
  logic [43:0]           src_req;
  logic [1:0]            bresp, rresp;
  logic [5:0]            ack_id, last_id;
  logic [5:0]            ids [3];
  irq_ctl_pkg::irq_req_s irq_o;
  int                    errors, compares, cyc;

  irq_ctl i_dut (
    .aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot(3'h0), .wvalid, .wready, .wdata,
    .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .arprot(3'h0), .rvalid,
    .rready, .rdata, .rresp, .src_req, .cpu_ack, .cpu_ack_id(ack_id), .irq_o, .irq_disabled,
    .interrupts_off_instruction(ioff), .interrupts_on_instruction(ion)
  );
  cpu_core_model i_cpu (
    .aclk, .aresetn, .ack_en, .ack_dly(dly), .irq_o, .cpu_ack, .cpu_ack_id(ack_id), .last_id
  );

  // 125 MHz clock
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  // cycle ceiling against hangs
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // byte address of slot k in window op
  function automatic logic [13:0] ad(input int k, input logic [1:0] op);
    return {op, 12'(12'h400 + k * 8)};
  endfunction

  task automatic wr(input logic [13:0] a, input logic [7:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    logic [1:0] tk;
    tk = 2'h0;
    awaddr  <= a;
    wdata   <= {24'h00_0000, d};
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    do begin
      @(posedge aclk);
      tk = tk | {awready, wready};
      awvalid <= ~tk[1];
      wvalid  <= ~tk[0];
    end while (tk != 2'h3);
    while (bvalid !== 1'b1) @(posedge aclk);
    chk(bresp, er, "bresp");
  endtask

  task automatic rdc(input logic [13:0] a, input logic [7:0] e, input logic [1:0] er);
    araddr  <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    chk(rdata, {24'h00_0000, e}, "rdata");
    chk(rresp, er, "rresp");
  endtask

  // let the cpu model take one request
  task automatic take(input logic [5:0] id);
    int n;
    n = 0;
    ack_en <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
    end while (irq_disabled !== 1'b1 && n < 40);
    ack_en <= 1'b0;
    chk(irq_disabled, 1'b1, "not disabled");
    chk(last_id, id, "acked id");
  endtask

  task automatic pulse(input logic on);
    ion  <= on;
    ioff <= ~on;
    @(posedge aclk);
    ion  <= 1'b0;
    ioff <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask

  // main sequence
  initial begin
    {awvalid, wvalid, arvalid, ack_en, ion, ioff, aresetn} = 7'h00;
    {bready, rready} = 2'h3;
    {awaddr, araddr, wstrb, dly} = 36'h0_0000_0000;
    wdata = 32'h0000_0000;
    src_req = 44'h000_0000_0000;
    ids = '{6'h14, 6'h1E, 6'h03};
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    for (int k = 0; k < 44; k++)
      rdc(ad(k, 2'h0), (k inside {[8:11]}) ? 8'h00 : 8'h47, {k inside {[8:11]}, 1'b0});
    rdc(14'h0404, 8'h00, 2'h2);
    rdc(14'h3400, 8'h00, 2'h2);
    wr(ad(9, 2'h0), 8'hFF, 4'h1, 2'h2);
    $display("test map done");
    wr(ad(0, 2'h0), 8'hFF, 4'h1, 2'h0);
    rdc(ad(0, 2'h0), 8'hC7, 2'h0);
    wr(ad(0, 2'h0), 8'h00, 4'h0, 2'h0);
    wr(ad(0, 2'h2), 8'h40, 4'h1, 2'h0);
    rdc(ad(0, 2'h0), 8'h87, 2'h0);
    wr(ad(0, 2'h1), 8'h40, 4'h1, 2'h0);
    rdc(ad(0, 2'h0), 8'hC7, 2'h0);
    wr(ad(0, 2'h0), 8'h47, 4'h1, 2'h0);
    for (int l = 0; l < 8; l++) begin
      wr(ad(2, 2'h0), 8'h80 | 8'(l), 4'h1, 2'h0);
      rdc(ad(2, 2'h0), 8'h80 | 8'(l), 2'h0);
      chk(irq_o, {1'b1, 6'h02, 3'(l)}, "level");
    end
    wr(ad(2, 2'h0), 8'h47, 4'h1, 2'h0);
    {bready, rready} <= 2'h0;
    wr(ad(0, 2'h0), 8'h47, 4'h1, 2'h0);
    rdc(ad(0, 2'h0), 8'h47, 2'h0);
    repeat (2) @(posedge aclk);
    chk(rdata, 32'h0000_0047, "rdata held");
    chk(bvalid, 1'b1, "bvalid held");
    {bready, rready} <= 2'h3;
    @(posedge aclk);
    $display("test access done");
    wr(ad(5, 2'h0), 8'h43, 4'h1, 2'h0);
    src_req[5] <= 1'b1;
    @(posedge aclk);
    src_req[5] <= 1'b0;
    repeat (2) @(posedge aclk);
    chk(irq_o.valid, 1'b0, "masked offered");
    rdc(ad(5, 2'h0), 8'hC3, 2'h0);
    wr(ad(5, 2'h2), 8'h40, 4'h1, 2'h0);
    repeat (2) @(posedge aclk);
    chk(irq_o, {1'b1, 6'h05, 3'h3}, "offer");
    dly <= 4'h3;
    take(6'h05);
    rdc(ad(5, 2'h0), 8'h03, 2'h0);
    $display("test pending done");
    pulse(1'b1);
    wr(ad(3, 2'h0), 8'h84, 4'h1, 2'h0);
    wr(ad(20, 2'h0), 8'h82, 4'h1, 2'h0);
    wr(ad(30, 2'h0), 8'h82, 4'h1, 2'h0);
    repeat (2) @(posedge aclk);
    chk(irq_o, {1'b1, 6'h14, 3'h2}, "best");
    pulse(1'b0);
    chk(irq_o.valid, 1'b0, "offered while off");
    dly <= 4'h0;
    for (int i = 0; i < 3; i++) begin
      pulse(1'b1);
      take(ids[i]);
    end
    pulse(1'b1);
    $display("test priority done");
    wr(ad(7, 2'h0), 8'h47, 4'h1, 2'h0);
    pulse(1'b0);
    src_req[7] <= 1'b1;
    wr(ad(7, 2'h2), 8'h80, 4'h1, 2'h0);
    src_req[7] <= 1'b0;
    rdc(ad(7, 2'h0), 8'hC7, 2'h0);
    wr(ad(7, 2'h2), 8'h80, 4'h1, 2'h0);
    rdc(ad(7, 2'h0), 8'h47, 2'h0);
    pulse(1'b1);
    $display("test race done");
    report_and_stop();
  end
endmodule
